// ---- i2csq_regs.svh ----
// register offsets, field positions and reset values of the sequence control
`ifndef I2CSQ_REGS_SVH
`define I2CSQ_REGS_SVH

`define I2CSQ_OFS_CTRL   8'h00
`define I2CSQ_OFS_STAT   8'h04
`define I2CSQ_OFS_MASK   8'h08
`define I2CSQ_OFS_RXD    8'h0c
`define I2CSQ_OFS_BRG    8'h10

`define I2CSQ_B_START    0
`define I2CSQ_B_RESTART  1
`define I2CSQ_B_STOP     2
`define I2CSQ_B_RECV     3
`define I2CSQ_B_ACK      4
`define I2CSQ_B_ACKVAL   5
`define I2CSQ_B_STRETCH  6
`define I2CSQ_B_GCIRQ    7
`define I2CSQ_B_CLKREL   12
`define I2CSQ_B_ON       15

`define I2CSQ_CTRL_W     16
`define I2CSQ_CTRL_RST   16'h1000
`define I2CSQ_CTRL_WMASK 16'h90ff

`define I2CSQ_EV_GC      0
`define I2CSQ_EV_DONE    1
`define I2CSQ_EV_RXB     2
`define I2CSQ_EV_W       3

`define I2CSQ_BRG_RST    16'h007d
`define I2CSQ_GC_ADDR    8'h00
`define I2CSQ_LAST_BIT   3'h7
`define I2CSQ_PH_LAST    2'h3

`endif

// ---- i2csq_pkg.sv ----
// types shared by the two-wire sequence control block
`default_nettype none
package i2csq_pkg;

	// released level of each open-drain line (1 = let float high)
	typedef struct packed {
		logic scl;
		logic sda;
	} i2csq_pins_s;

	typedef enum logic [2:0] {
		MS_IDLE, MS_START, MS_RSTART, MS_STOP, MS_RECV, MS_ACK
	} i2csq_mst_e;

	typedef enum logic [1:0] {
		SL_IDLE, SL_ADDR, SL_ACK, SL_HOLD
	} i2csq_slv_e;

endpackage
`default_nettype wire

// ---- i2csq_ctrl.sv ----
// two-wire port: sequence triggers, general call and clock stretch, on APB
//
// What this block does
// - general call address raises interrupt when enabled
// - slave stretches SCL only when enabled
// - acknowledge slot carries ack_value, 1 is NACK
// - ack trigger drives acknowledge, self-clears at end
// - receive trigger clocks one byte, clears after eighth
// - stop trigger makes Stop, clears when complete
// - restart trigger makes Repeated Start, then clears
// - start trigger makes Start, then clears
`include "i2csq_regs.svh"
`default_nettype none
module i2csq_ctrl
	import i2csq_pkg::*;
(
	input  wire logic        clk_i,     // 200 MHz peripheral clock
	input  wire logic        rst_b_i,   // synchronous reset, low active
	input  wire logic        psel_i,    // apb select
	input  wire logic        penable_i, // apb access phase
	input  wire logic        pwrite_i,  // apb write
	input  wire logic [7:0]  paddr_i,   // apb byte address
	input  wire logic [31:0] pwdata_i,  // apb write data
	output logic      [31:0] prdata_o,  // apb read data
	output logic             pready_o,  // apb ready
	output logic             pslverr_o, // apb error, unmapped address
	input  wire logic        scl_i,     // clock line level
	output logic             scl_o,     // clock line drive value
	output logic             scl_oe_o,  // clock line pulled low
	input  wire logic        sda_i,     // data line level
	output logic             sda_o,     // data line drive value
	output logic             sda_oe_o,  // data line pulled low
	output logic             irq_o      // level interrupt
);

	////////////////////////////////////////////////////////////////////
	// pin synchronisers; first stage read only by the second

	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_q;
	logic       sda_q;
	logic       scl_s;
	logic       sda_s;

	// two flops per line, then one more for edge finding
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_i};
			sda_sync <= {sda_sync[0], sda_i};
			scl_q    <= scl_sync[1];
			sda_q    <= sda_sync[1];
		end
	end
	assign scl_s = scl_sync[1];
	assign sda_s = sda_sync[1];

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise  = scl_s & ~scl_q;
	assign scl_fall  = ~scl_s & scl_q;
	assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
	assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

	////////////////////////////////////////////////////////////////////
	// register file and apb slave

	logic [`I2CSQ_CTRL_W-1:0] ctrl;
	logic [`I2CSQ_EV_W-1:0]   stat;
	logic [`I2CSQ_EV_W-1:0]   mask;
	logic [`I2CSQ_EV_W-1:0]   rd_snap;
	logic [7:0]               rxd;
	logic [15:0]              brg;
	logic [`I2CSQ_CTRL_W-1:0] next_ctrl;
	logic [`I2CSQ_EV_W-1:0]   next_stat;
	logic [`I2CSQ_EV_W-1:0]   next_mask;
	logic [`I2CSQ_EV_W-1:0]   next_rd_snap;
	logic [15:0]              next_brg;
	logic [31:0]              next_prdata;
	logic                     next_pready;
	logic                     next_pslverr;
	logic                     setup;
	logic                     acc;
	logic                     hit;

	// hardware events and trigger clears from the engines below
	logic [`I2CSQ_EV_W-1:0]   ev;
	logic [`I2CSQ_CTRL_W-1:0] hw_clr;
	logic [`I2CSQ_CTRL_W-1:0] rel_clr;

	assign setup = psel_i & ~penable_i & ~pready_o;
	assign acc   = psel_i & penable_i & pready_o;

	// decode; data is prepared in setup, answered in access
	always_comb begin
		hit         = 1'b1;
		next_prdata = 32'h0000_0000;
		unique case (paddr_i)
			`I2CSQ_OFS_CTRL: next_prdata[`I2CSQ_CTRL_W-1:0] = ctrl;
			`I2CSQ_OFS_STAT: next_prdata[`I2CSQ_EV_W-1:0]   = stat;
			`I2CSQ_OFS_MASK: next_prdata[`I2CSQ_EV_W-1:0]   = mask;
			`I2CSQ_OFS_RXD:  next_prdata[7:0]               = rxd;
			`I2CSQ_OFS_BRG:  next_prdata[15:0]              = brg;
			default:         hit                            = 1'b0;
		endcase
		if (!setup)
			next_prdata = prdata_o;
		next_pready  = setup;
		next_pslverr = setup & ~hit;
	end

	// register updates; hardware set wins over a read clear
	always_comb begin
		next_ctrl    = ctrl & ~(hw_clr | rel_clr);
		next_mask    = mask;
		next_brg     = brg;
		next_rd_snap = rd_snap;
		next_stat    = stat;
		if (setup)
			next_rd_snap = (paddr_i == `I2CSQ_OFS_STAT && !pwrite_i) ?
			               stat : '0;
		if (acc && pwrite_i) begin
			unique case (paddr_i)
				`I2CSQ_OFS_CTRL:
					next_ctrl = (pwdata_i[`I2CSQ_CTRL_W-1:0] &
					             `I2CSQ_CTRL_WMASK) |
					            (ctrl & ~`I2CSQ_CTRL_WMASK);
				`I2CSQ_OFS_MASK: next_mask = pwdata_i[`I2CSQ_EV_W-1:0];
				`I2CSQ_OFS_BRG:  next_brg  = pwdata_i[15:0];
				default: ;
			endcase
		end
		if (acc)
			next_stat = stat & ~rd_snap;
		next_stat = next_stat | ev;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ctrl      <= `I2CSQ_CTRL_RST;
			stat      <= '0;
			mask      <= '0;
			rd_snap   <= '0;
			brg       <= `I2CSQ_BRG_RST;
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			irq_o     <= 1'b0;
		end else begin
			ctrl      <= next_ctrl;
			stat      <= next_stat;
			mask      <= next_mask;
			rd_snap   <= next_rd_snap;
			brg       <= next_brg;
			prdata_o  <= next_prdata;
			pready_o  <= next_pready;
			pslverr_o <= next_pslverr;
			irq_o     <= |(next_stat & next_mask);
		end
	end

	logic on;
	assign on = ctrl[`I2CSQ_B_ON];

	////////////////////////////////////////////////////////////////////
	// quarter-bit timing enable; waits while a slave stretches SCL

	i2csq_pins_s m_pins;
	logic [15:0] q_cnt;
	logic [15:0] next_q_cnt;
	logic        q_tick;
	logic        stretched;

	// count only once our released clock is really high
	always_comb begin
		stretched  = m_pins.scl & ~scl_s;
		q_tick     = (q_cnt >= brg) & ~stretched;
		next_q_cnt = q_cnt + 16'h0001;
		if (q_tick || stretched || !on)
			next_q_cnt = 16'h0000;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			q_cnt <= 16'h0000;
		else
			q_cnt <= next_q_cnt;
	end

	////////////////////////////////////////////////////////////////////
	// master sequence engine

	i2csq_mst_e  m_st;
	i2csq_mst_e  next_m_st;
	logic [1:0]  m_ph;
	logic [1:0]  next_m_ph;
	logic [2:0]  m_bit;
	logic [2:0]  next_m_bit;
	logic [7:0]  m_sh;
	logic [7:0]  next_m_sh;
	logic [7:0]  next_rxd;
	i2csq_pins_s next_m_pins;
	logic        m_done;
	logic        m_rxb;

	// one trigger at a time; start has priority if several are set
	always_comb begin
		next_m_st   = m_st;
		next_m_ph   = m_ph;
		next_m_bit  = m_bit;
		next_m_sh   = m_sh;
		next_m_pins = m_pins;
		next_rxd    = rxd;
		m_done      = 1'b0;
		m_rxb       = 1'b0;
		hw_clr      = '0;
		unique case (m_st)
			MS_IDLE: begin
				next_m_ph  = 2'h0;
				next_m_bit = 3'h0;
				if (on && q_tick) begin
					if (ctrl[`I2CSQ_B_START])
						next_m_st = MS_START;
					else if (ctrl[`I2CSQ_B_RESTART])
						next_m_st = MS_RSTART;
					else if (ctrl[`I2CSQ_B_STOP])
						next_m_st = MS_STOP;
					else if (ctrl[`I2CSQ_B_RECV])
						next_m_st = MS_RECV;
					else if (ctrl[`I2CSQ_B_ACK])
						next_m_st = MS_ACK;
				end
			end
			MS_START: if (q_tick) begin
				next_m_ph = m_ph + 2'h1;
				unique case (m_ph)
					2'h0: next_m_pins = '{scl: 1'b1, sda: 1'b1};
					2'h1: next_m_pins = '{scl: 1'b1, sda: 1'b0};
					default: begin
						next_m_pins = '{scl: 1'b0, sda: 1'b0};
						next_m_st   = MS_IDLE;
						m_done      = 1'b1;
						hw_clr[`I2CSQ_B_START] = 1'b1;
					end
				endcase
			end
			MS_RSTART: if (q_tick) begin
				next_m_ph = m_ph + 2'h1;
				unique case (m_ph)
					2'h0: next_m_pins = '{scl: 1'b0, sda: 1'b1};
					2'h1: next_m_pins = '{scl: 1'b1, sda: 1'b1};
					2'h2: next_m_pins = '{scl: 1'b1, sda: 1'b0};
					default: begin
						next_m_pins = '{scl: 1'b0, sda: 1'b0};
						next_m_st   = MS_IDLE;
						m_done      = 1'b1;
						hw_clr[`I2CSQ_B_RESTART] = 1'b1;
					end
				endcase
			end
			MS_STOP: if (q_tick) begin
				next_m_ph = m_ph + 2'h1;
				unique case (m_ph)
					2'h0: next_m_pins = '{scl: 1'b0, sda: 1'b0};
					2'h1: next_m_pins = '{scl: 1'b1, sda: 1'b0};
					default: begin
						next_m_pins = '{scl: 1'b1, sda: 1'b1};
						next_m_st   = MS_IDLE;
						m_done      = 1'b1;
						hw_clr[`I2CSQ_B_STOP] = 1'b1;
					end
				endcase
			end
			MS_RECV: if (q_tick) begin
				next_m_ph = m_ph + 2'h1;
				unique case (m_ph)
					2'h0: next_m_pins = '{scl: 1'b0, sda: 1'b1};
					2'h1: next_m_pins = '{scl: 1'b1, sda: 1'b1};
					2'h2: next_m_sh   = {m_sh[6:0], sda_s};
					default: begin
						next_m_pins = '{scl: 1'b0, sda: 1'b1};
						next_m_bit  = m_bit + 3'h1;
						if (m_bit == `I2CSQ_LAST_BIT) begin
							next_m_st = MS_IDLE;
							next_rxd  = m_sh;
							m_rxb     = 1'b1;
							hw_clr[`I2CSQ_B_RECV] = 1'b1;
						end
					end
				endcase
			end
			MS_ACK: if (q_tick) begin
				next_m_ph = m_ph + 2'h1;
				unique case (m_ph)
					2'h0: next_m_pins = '{scl: 1'b0,
					                      sda: ctrl[`I2CSQ_B_ACKVAL]};
					2'h1: next_m_pins = '{scl: 1'b1,
					                      sda: ctrl[`I2CSQ_B_ACKVAL]};
					2'h2: ;
					default: begin
						next_m_pins = '{scl: 1'b0, sda: 1'b1};
						next_m_st   = MS_IDLE;
						m_done      = 1'b1;
						hw_clr[`I2CSQ_B_ACK] = 1'b1;
					end
				endcase
			end
			default: next_m_st = MS_IDLE;
		endcase
		if (!on) begin
			next_m_st   = MS_IDLE;
			next_m_pins = '{scl: 1'b1, sda: 1'b1};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			m_st   <= MS_IDLE;
			m_ph   <= 2'h0;
			m_bit  <= 3'h0;
			m_sh   <= 8'h00;
			rxd    <= 8'h00;
			m_pins <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			m_st   <= next_m_st;
			m_ph   <= next_m_ph;
			m_bit  <= next_m_bit;
			m_sh   <= next_m_sh;
			rxd    <= next_rxd;
			m_pins <= next_m_pins;
		end
	end

	////////////////////////////////////////////////////////////////////
	// slave watcher: general call address, ack and clock stretch

	i2csq_slv_e s_st;
	i2csq_slv_e next_s_st;
	logic [7:0] s_sh;
	logic [7:0] next_s_sh;
	logic [3:0] s_cnt;
	logic [3:0] next_s_cnt;
	logic       s_gc;
	logic       s_hold_clr;
	logic       s_ack_drv;
	logic       s_scl_hold;

	// only listens while our own master is idle
	always_comb begin
		next_s_st  = s_st;
		next_s_sh  = s_sh;
		next_s_cnt = s_cnt;
		s_gc       = 1'b0;
		s_hold_clr = 1'b0;
		unique case (s_st)
			SL_IDLE: ;
			SL_ADDR: begin
				if (scl_rise && s_cnt != 4'h8) begin
					next_s_sh  = {s_sh[6:0], sda_s};
					next_s_cnt = s_cnt + 4'h1;
				end
				if (scl_fall && s_cnt == 4'h8) begin
					if (ctrl[`I2CSQ_B_GCIRQ] &&
					    s_sh == `I2CSQ_GC_ADDR) begin
						next_s_st = SL_ACK;
						s_gc      = 1'b1;
					end else
						next_s_st = SL_IDLE;
				end
			end
			SL_ACK: if (scl_fall) begin
				if (ctrl[`I2CSQ_B_STRETCH]) begin
					next_s_st  = SL_HOLD;
					s_hold_clr = 1'b1;
				end else
					next_s_st = SL_IDLE;
			end
			SL_HOLD: if (ctrl[`I2CSQ_B_CLKREL])
				next_s_st = SL_IDLE;
		endcase
		if (bus_start) begin
			next_s_st  = SL_ADDR;
			next_s_cnt = 4'h0;
		end
		if (bus_stop || !on || m_st != MS_IDLE)
			next_s_st = SL_IDLE;
	end

	assign s_ack_drv  = (s_st == SL_ACK);
	assign s_scl_hold = (s_st == SL_HOLD);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s_st  <= SL_IDLE;
			s_sh  <= 8'h00;
			s_cnt <= 4'h0;
		end else begin
			s_st  <= next_s_st;
			s_sh  <= next_s_sh;
			s_cnt <= next_s_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// events, release-bit clear and pin drivers

	// entering the hold clears the release bit; software writes it back to one to free the clock, reset also sets it
	always_comb begin
		rel_clr = '0;
		rel_clr[`I2CSQ_B_CLKREL] = s_hold_clr;
		ev = '0;
		ev[`I2CSQ_EV_GC]   = s_gc;
		ev[`I2CSQ_EV_DONE] = m_done;
		ev[`I2CSQ_EV_RXB]  = m_rxb;
	end

	// open drain: only ever pull low, value flops are held at zero
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			scl_o    <= 1'b0;
			sda_o    <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			scl_o    <= 1'b0;
			sda_o    <= 1'b0;
			scl_oe_o <= ~m_pins.scl | s_scl_hold;
			sda_oe_o <= ~m_pins.sda | s_ack_drv;
		end
	end

endmodule
`default_nettype wire

// ---- i2csq_ctrl_monitor.sv ----
// port checker of the two-wire sequence control
`include "i2csq_regs.svh"
`default_nettype none
module i2csq_ctrl_monitor (
	input wire logic        clk_i,     // clock
	input wire logic        rst_b_i,   // reset
	input wire logic        psel_i,    // select
	input wire logic        penable_i, // access
	input wire logic        pwrite_i,  // write
	input wire logic [7:0]  paddr_i,   // address
	input wire logic [31:0] pwdata_i,  // data
	input wire logic        pready_o,  // ready
	input wire logic        pslverr_o, // error
	input wire logic        scl_o,     // clock value
	input wire logic        scl_oe_o,  // clock pull
	input wire logic        sda_o,     // data value
	input wire logic        sda_oe_o,  // data pull
	input wire logic        irq_o      // interrupt
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic acc;
	logic wr_c;
	// completed writes, control only with the enable bit set
	assign acc = psel_i && penable_i && pready_o && pwrite_i;
	assign wr_c = acc && paddr_i == `I2CSQ_OFS_CTRL && pwdata_i[15];
	////////////////////////////////////////
	// line events: data moves while the clock line is free, or the clock is freed with data held or free
	sequence s_start;
		$rose(sda_oe_o) && !scl_oe_o;
	endsequence
	sequence s_stop;
		$fell(sda_oe_o) && !scl_oe_o;
	endsequence
	sequence s_clk_lo_data;
		$fell(scl_oe_o) && sda_oe_o;
	endsequence
	sequence s_clk_hi_data;
		$fell(scl_oe_o) && !sda_oe_o;
	endsequence
	a_start_cond: assert property (
		wr_c && pwdata_i[0] |-> ##[1:1000] s_start)
		else $error("start condition missing");
	a_restart_cond: assert property (
		wr_c && pwdata_i[1] |-> ##[1:1000] s_start)
		else $error("repeated start missing");
	a_stop_cond: assert property (
		wr_c && pwdata_i[2] |-> ##[1:1000] s_stop)
		else $error("stop condition missing");
	a_recv_free: assert property (
		wr_c && pwdata_i[3] |-> ##[1:1000] s_clk_hi_data)
		else $error("receive does not free data");
	a_ack_low: assert property (
		wr_c && pwdata_i[4] && !pwdata_i[5] |-> ##[1:1000] s_clk_lo_data)
		else $error("ack slot not low");
	a_nack_high: assert property (
		wr_c && pwdata_i[4] && pwdata_i[5] |-> ##[1:1000] s_clk_hi_data)
		else $error("nack slot not high");
	// bus timing, the open-drain outputs and interrupt masking
	a_ready_next: assert property (psel_i && !penable_i |=> pready_o)
		else $error("ready late");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready too long");
	a_err_unmapped: assert property (
		pready_o && paddr_i > `I2CSQ_OFS_BRG |-> pslverr_o)
		else $error("unmapped without error");
	a_pins_low: assert property (!scl_o && !sda_o)
		else $error("line value not low");
	a_mask_quiet: assert property (acc && paddr_i == `I2CSQ_OFS_MASK
		&& pwdata_i[2:0] == 3'h0 |-> ##2 !irq_o)
		else $error("masked interrupt seen");
endmodule
bind i2csq_ctrl i2csq_ctrl_monitor i2csq_ctrl_monitor_i (
	.clk_i     (clk_i),
	.rst_b_i   (rst_b_i),
	.psel_i    (psel_i),
	.penable_i (penable_i),
	.pwrite_i  (pwrite_i),
	.paddr_i   (paddr_i),
	.pwdata_i  (pwdata_i),
	.pready_o  (pready_o),
	.pslverr_o (pslverr_o),
	.scl_o     (scl_o),
	.scl_oe_o  (scl_oe_o),
	.sda_o     (sda_o),
	.sda_oe_o  (sda_oe_o),
	.irq_o     (irq_o)
);
`default_nettype wire

// ---- i2csq_remote.sv ----
// far side: remote slave transmitter and remote master
`default_nettype none
module i2csq_remote (
	input  wire logic clk_i,    // bench clock
	input  wire logic scl_oe_i, // block pulls clock
	input  wire logic sda_oe_i, // block pulls data
	output logic      scl_o,    // clock line level
	output logic      sda_o     // data line level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       scl_low = 1'h0;
	logic       sda_low = 1'h0;
	logic       act = 1'h0;
	logic [7:0] tx;
	int         cnt;
	int         stretch_n;
	// pull-ups: a released line floats high
	assign scl_o = !(scl_oe_i || scl_low);
	assign sda_o = !(sda_oe_i || sda_low);
	////////////////////////////////////////
	// data set while clock low, then a slow slave stretches
	always @(negedge scl_o) begin
		if (act) begin
			cnt = cnt + 1;
			sda_low = cnt < 8 ? !tx[7 - cnt] : 1'h0;
			act = cnt < 8;
			scl_low = 1'h1;
			repeat (stretch_n) @(posedge clk_i);
			scl_low = 1'h0;
		end
	end
	task automatic load(input logic [7:0] b, input int s);
		tx = b;
		cnt = 0;
		stretch_n = s;
		sda_low = !b[7];
		act = 1'h1;
	endtask
	// remote master: start, address, ack slot, clock held low
	task automatic gc_addr(input logic [7:0] a, output logic ack);
		#3;
		sda_low = 1'h1;
		#80;
		for (int i = 0; i < 9; i++) begin
			scl_low = 1'h1;
			#40;
			sda_low = i < 8 ? !a[7 - i] : 1'h0;
			#40;
			scl_low = 1'h0;
			#40;
			ack = !sda_o;
			#40;
		end
		scl_low = 1'h1;
		#80;
	endtask
	task automatic stop();
		sda_low = 1'h1;
		#40;
		scl_low = 1'h0;
		#80;
		sda_low = 1'h0;
		#80;
	endtask
endmodule
`default_nettype wire

// ---- i2csq_ctrl_tb.sv ----
// self-checking bench of the sequence control block
`include "i2csq_regs.svh"
`default_nettype none
module i2csq_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'h0;
	logic        rst_b_i = 1'h0;
	logic        psel_i = 1'h0;
	logic        penable_i = 1'h0;
	logic        pwrite_i = 1'h0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic        pready_o, pslverr_o, scl_i, scl_o, scl_oe_o;
	logic        sda_i, sda_o, sda_oe_o, irq_o, ack, perr;
	logic [31:0] rd;
	logic [31:0] seed = 32'hba63;
	logic [31:0] trig [7] = '{32'h9001, 32'h9008, 32'h9010, 32'h9008,
		32'h9030, 32'h9002, 32'h9004};
	int          num_errors = 0;
	int          samples_checked = 0;
	i2csq_ctrl i2csq_ctrl_i (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.psel_i    (psel_i),
		.penable_i (penable_i),
		.pwrite_i  (pwrite_i),
		.paddr_i   (paddr_i),
		.pwdata_i  (pwdata_i),
		.prdata_o  (prdata_o),
		.pready_o  (pready_o),
		.pslverr_o (pslverr_o),
		.scl_i     (scl_i),
		.scl_o     (scl_o),
		.scl_oe_o  (scl_oe_o),
		.sda_i     (sda_i),
		.sda_o     (sda_o),
		.sda_oe_o  (sda_oe_o),
		.irq_o     (irq_o)
	);
	i2csq_remote i2csq_remote_i (.clk_i(clk_i), .scl_oe_i(scl_oe_o),
		.sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
	// 200 MHz clock
	always #2.5 clk_i = ~clk_i;
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// a receive reports a byte, every other sequence reports done
	function automatic logic [31:0] done_stat(input logic [31:0] c);
		return c[`I2CSQ_B_RECV] ? 32'h4 : 32'h2;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// idle edge first, so no access follows a disable at once
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel_i <= 1'h1;
		penable_i <= 1'h0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'h1 && n < 16);
		if (pready_o !== 1'h1) begin
			chk(n, 0);
			test_done();
		end
		rd = prdata_o;
		perr = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask
	task automatic wait_clr(input logic [31:0] m);
		int n;
		n = 0;
		do begin
			apb(1'h0, `I2CSQ_OFS_CTRL, 32'h0);
			n++;
		end while ((rd & m) !== 32'h0 && n < 500);
		if ((rd & m) !== 32'h0) begin
			chk(n, 0);
			test_done();
		end
	endtask
	////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'h1;
		// reset values, unmapped and read-only places
		apb(1'h0, `I2CSQ_OFS_CTRL, 32'h0);
		chk(rd, `I2CSQ_CTRL_RST);
		apb(1'h0, `I2CSQ_OFS_BRG, 32'h0);
		chk(rd, `I2CSQ_BRG_RST);
		apb(1'h1, 8'h14, 32'hffffffff);
		chk(perr, 1'h1);
		apb(1'h1, `I2CSQ_OFS_STAT, 32'h7);
		apb(1'h0, `I2CSQ_OFS_STAT, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			apb(1'h1, `I2CSQ_OFS_CTRL, seed & 32'h10e0);
			apb(1'h0, `I2CSQ_OFS_CTRL, 32'h0);
			chk(rd, seed & 32'h10e0);
		end
		apb(1'h1, `I2CSQ_OFS_BRG, 32'h2);
		apb(1'h1, `I2CSQ_OFS_MASK, 32'h7);
		$display("test registers done");
		// one trigger at a time, next only after it clears
		foreach (trig[i]) begin
			if (trig[i][`I2CSQ_B_RECV]) begin
				seed = lfsr(seed);
				// hold SCL past our release, so the quarter count waits
				i2csq_remote_i.load(seed[7:0], i * 8);
			end
			apb(1'h1, `I2CSQ_OFS_CTRL, trig[i]);
			wait_clr(trig[i] & 32'h1f);
			chk(irq_o, 1'h1);
			if (i == 0) begin
				apb(1'h1, `I2CSQ_OFS_MASK, 32'h0);
				repeat (2) @(posedge clk_i);
				chk(irq_o, 1'h0);
				apb(1'h1, `I2CSQ_OFS_MASK, 32'h7);
				repeat (2) @(posedge clk_i);
				chk(irq_o, 1'h1);
			end
			apb(1'h0, `I2CSQ_OFS_STAT, 32'h0);
			chk(rd, done_stat(trig[i]));
			repeat (2) @(posedge clk_i);
			chk(irq_o, 1'h0);
			if (trig[i][`I2CSQ_B_RECV]) begin
				apb(1'h0, `I2CSQ_OFS_RXD, 32'h0);
				chk(rd, {24'h0, seed[7:0]});
			end
		end
		$display("test sequences done");
		// remote master calls everyone; slave acks and holds if enabled
		for (int g = 0; g < 2; g++) begin
			apb(1'h1, `I2CSQ_OFS_CTRL, 32'(32'h8000 | (g << 7) | (g << 6)));
			i2csq_remote_i.gc_addr(`I2CSQ_GC_ADDR, ack);
			repeat (6) @(posedge clk_i);
			chk(ack, g);
			chk(scl_oe_o, g);
			chk(irq_o, g);
			apb(1'h0, `I2CSQ_OFS_STAT, 32'h0);
			chk(rd, g);
			apb(1'h1, `I2CSQ_OFS_CTRL, 32'h9000);
			repeat (6) @(posedge clk_i);
			chk(scl_oe_o, 1'h0);
			i2csq_remote_i.stop();
		end
		$display("test general call done");
		test_done();
	end
endmodule
`default_nettype wire
